// *** logic/dspmac_regs.svh ***
// Register map, field positions and widths of the multiply-accumulate block.
// Assumes it is included by bare name before the package and the block.
`ifndef DSPMAC_REGS_SVH
`define DSPMAC_REGS_SVH

// ********************************************************************
// Bus register offsets and reset values
// ********************************************************************
`define DSPMAC_ADDR_W      8
`define DSPMAC_CFG_OFS     8'h00
`define DSPMAC_STAT_OFS    8'h04
`define DSPMAC_CFG_RST     32'h0000_0000
`define DSPMAC_RESP_OKAY   2'h0
`define DSPMAC_RESP_SLVERR 2'h2

// ********************************************************************
// Field positions
// ********************************************************************
`define DSPMAC_F_MODE      0
`define DSPMAC_F_WIDTH     2
`define DSPMAC_F_INREG     4
`define DSPMAC_F_PIPE      5
`define DSPMAC_F_SHA       6
`define DSPMAC_F_SHB       7
`define DSPMAC_F_CDEP      8
`define DSPMAC_ST_OVF      0
`define DSPMAC_ST_SHA      2
`define DSPMAC_ST_SHB      3
`define DSPMAC_ST_MODE     4
`define DSPMAC_ST_WIDTH    6

// ********************************************************************
// Datapath widths and control groups
// ********************************************************************
`define DSPMAC_LANE_W      18
`define DSPMAC_PROD_W      36
`define DSPMAC_ACC_W       52
`define DSPMAC_GRP_IN      0
`define DSPMAC_GRP_PIPE    1
`define DSPMAC_GRP_ACC     2
`define DSPMAC_GRP_OUT     3
`define DSPMAC_DEP_0       2'h0
`define DSPMAC_DEP_1       2'h1

`endif

// *** logic/dspmac_pkg.sv ***
// Types shared by the multiply-accumulate block and its bench.
// Assumes the register header sits beside it.
`include "dspmac_regs.svh"

package dspmac_pkg;

	// ********************************************************************
	// Datapath types
	// ********************************************************************
	typedef logic [`DSPMAC_LANE_W-1:0]   dspmac_lane_t;
	typedef logic [`DSPMAC_PROD_W-1:0]   dspmac_prod_t;
	typedef logic [2*`DSPMAC_PROD_W-1:0] dspmac_wide_t;
	typedef logic [`DSPMAC_ACC_W-1:0]    dspmac_acc_t;
	typedef dspmac_lane_t [7:0]          dspmac_res_t;

	typedef enum logic [1:0] {
		DSPMAC_SIMPLE = 2'h0,
		DSPMAC_MAC    = 2'h1,
		DSPMAC_ADD2   = 2'h2,
		DSPMAC_ADD4   = 2'h3
	} dspmac_mode_t;

	typedef enum logic [1:0] {
		DSPMAC_W9  = 2'h0,
		DSPMAC_W18 = 2'h1,
		DSPMAC_W36 = 2'h2
	} dspmac_width_t;

	// Shared control bus, eighteen signals, with the row each comes from
	typedef struct packed {
		logic [3:0] clock_en;                  // Rows 3..6
		logic [3:0] clear;                     // Rows 2, 4, 5, 7
		logic [3:0] ena;                       // Rows 3..6
		logic       sign_a;                    // Row 1
		logic       sign_b;                    // Row 6
		logic       add_subtract_select_upper; // Row 3
		logic       add_subtract_select_lower; // Row 8
		logic [1:0] accum_load;                // Rows 2 and 7
	} dspmac_ctrl_t;

	typedef struct packed {
		logic                     awvalid;
		logic [`DSPMAC_ADDR_W-1:0] awaddr;
		logic                     wvalid;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bready;
		logic                     arvalid;
		logic [`DSPMAC_ADDR_W-1:0] araddr;
		logic                     rready;
	} dspmac_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dspmac_axi_rsp_t;

endpackage : dspmac_pkg

// *** logic/dspmac_block.sv ***
// Multiply-accumulate block: four 18-bit sub-blocks, adders, accumulators.
// Assumes operands and controls come from logic on the same clock.
`timescale 1ns/10ps
`include "dspmac_regs.svh"

// Behaviour
// - Widest mode joins four 18-bit multipliers into one 36x36 product.
// - No input shift chain in the 36x36 multiply.
// - Product register may act as pipeline stage of the wide multiply.
// - Accumulate mode gives one or two channels of up to 18 bits.
// - First and third multipliers unused in accumulate mode.
// - Each accumulator is 52 bits: 36-bit product plus 16 guard bits.
// - Load inputs and overflow act only in accumulate mode.
// - Add/subtract select may subtract products; overflow also flags underflow.
// - Each first-stage unit adds or subtracts a pair of products.
// - Pairs form complex products: one at 18 bits, two at 9 bits.
// - Summation adds both first-stage results: four products summed.
// - FIR use: data shift chain plus coefficients loaded serially or parallel.
// - One block makes a four-tap 18-bit filter; longer ones cascade.
// - Shift chains pass out to the next block of the column.
// - Eight interface rows, each half a sub-block, 18 in, 18 out.
// - Per row nine result bits go left, nine right, all 18 routed.
// - Eighteen-signal control bus: clocks, clears, gates, signs, selects, loads.
// - Controls come from fixed rows, as the control struct records.
// - Rows carry A1,B1..A4,B4 inputs and result lanes in order.
// - Operands take zero or one stage, controls zero, one or two.
// - Sign select high means signed; product signed if either is.
// - Add/subtract select high adds, low subtracts.
// - Load strobe replaces the total with the current product.
// - Overflow flag is registered and not sticky.
module dspmac_block (
	input  wire logic                          clock_i,
	input  wire logic                          resetn_i,
	input  wire dspmac_pkg::dspmac_axi_req_t   axi_req_i,
	output dspmac_pkg::dspmac_axi_rsp_t        axi_rsp_o,
	input  wire dspmac_pkg::dspmac_ctrl_t      ctrl_i,
	input  wire dspmac_pkg::dspmac_lane_t [3:0] operand_a_lane_i,
	input  wire dspmac_pkg::dspmac_lane_t [3:0] operand_b_lane_i,
	input  wire dspmac_pkg::dspmac_lane_t      shift_in_a_i,
	input  wire dspmac_pkg::dspmac_lane_t      shift_in_b_i,
	output dspmac_pkg::dspmac_lane_t           shift_out_a_o,
	output dspmac_pkg::dspmac_lane_t           shift_out_b_o,
	output dspmac_pkg::dspmac_res_t            result_lane_o,
	output logic [7:0][8:0]                    result_left_o,
	output logic [7:0][8:0]                    result_right_o,
	output logic [1:0]                         overflow_o
);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	// ********************************************************************
	// Arithmetic helpers
	// ********************************************************************
	// One sub-block: a full 18x18 product or two 9x9 products
	function automatic dspmac_pkg::dspmac_prod_t mul18(
		input dspmac_pkg::dspmac_lane_t x, y, input logic xs, ys, h);
		logic signed [37:0] pf;
		logic signed [19:0] pl;
		logic signed [19:0] ph;
		pf = $signed({xs & x[17], x}) * $signed({ys & y[17], y});
		pl = $signed({xs & x[8], x[8:0]}) * $signed({ys & y[8], y[8:0]});
		ph = $signed({xs & x[17], x[17:9]}) * $signed({ys & y[17], y[17:9]});
		mul18 = h ? {ph[17:0], pl[17:0]} : pf[35:0];
	endfunction : mul18

	// Extend a product to 72 bits, per half in nine-bit mode
	function automatic dspmac_pkg::dspmac_wide_t ext(
		input dspmac_pkg::dspmac_prod_t v, input logic s, h);
		ext = h ? {{18{s & v[35]}}, v[35:18], {18{s & v[17]}}, v[17:0]}
			: {{36{s & v[35]}}, v};
	endfunction : ext

	// Add or subtract, halves kept apart in nine-bit mode
	function automatic dspmac_pkg::dspmac_wide_t as72(
		input dspmac_pkg::dspmac_wide_t p, q, input logic add, h);
		dspmac_pkg::dspmac_wide_t f;
		dspmac_pkg::dspmac_prod_t lo;
		dspmac_pkg::dspmac_prod_t hi;
		f = add ? p + q : p - q;
		lo = add ? p[35:0] + q[35:0] : p[35:0] - q[35:0];
		hi = add ? p[71:36] + q[71:36] : p[71:36] - q[71:36];
		as72 = h ? {hi, lo} : f;
	endfunction : as72

	// ********************************************************************
	// Configuration decode
	// ********************************************************************
	logic [31:0]              cfg_reg;
	dspmac_pkg::dspmac_mode_t mode;
	logic                     w36;
	logic                     h9;
	logic                     is_mac;
	logic                     in_reg;
	logic                     pipe_on;
	logic                     sh_a;
	logic                     sh_b;
	logic [1:0]               cdep;
	logic [3:0]               grp_en;
	logic                     in_step;
	logic                     acc_step;
	logic                     out_step;

	// Mode, width and stage options
	assign mode = dspmac_pkg::dspmac_mode_t'(cfg_reg[`DSPMAC_F_MODE +: 2]);
	assign w36 = (cfg_reg[`DSPMAC_F_WIDTH +: 2] == dspmac_pkg::DSPMAC_W36) && (mode == dspmac_pkg::DSPMAC_SIMPLE);
	assign is_mac = mode == dspmac_pkg::DSPMAC_MAC;
	assign h9 = (cfg_reg[`DSPMAC_F_WIDTH +: 2] == dspmac_pkg::DSPMAC_W9) && !is_mac;
	assign in_reg = cfg_reg[`DSPMAC_F_INREG];
	assign pipe_on = cfg_reg[`DSPMAC_F_PIPE];
	assign sh_a = cfg_reg[`DSPMAC_F_SHA] && !w36;
	assign sh_b = cfg_reg[`DSPMAC_F_SHB] && !w36;
	assign cdep = cfg_reg[`DSPMAC_F_CDEP +: 2];

	// Register groups: clock lane and gate together, clear wins
	assign grp_en = ctrl_i.clock_en & ctrl_i.ena;
	assign in_step = grp_en[`DSPMAC_GRP_IN] && !ctrl_i.clear[`DSPMAC_GRP_IN];
	assign acc_step = grp_en[`DSPMAC_GRP_ACC] && !ctrl_i.clear[`DSPMAC_GRP_ACC];
	assign out_step = grp_en[`DSPMAC_GRP_OUT] && !ctrl_i.clear[`DSPMAC_GRP_OUT];

	// ********************************************************************
	// Control pipeline
	// ********************************************************************
	dspmac_pkg::dspmac_ctrl_t ctrl_d1_reg;
	dspmac_pkg::dspmac_ctrl_t ctrl_d2_reg;
	dspmac_pkg::dspmac_ctrl_t cx;

	// Two delay stages for sign, select and load controls
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ctrl_d1_reg <= '0;
			ctrl_d2_reg <= '0;
		end else begin
			ctrl_d1_reg <= ctrl_i;
			ctrl_d2_reg <= ctrl_d1_reg;
		end
	end

	// Pick zero, one or two stages
	always_comb begin
		case (cdep)
			`DSPMAC_DEP_0: cx = ctrl_i;
			`DSPMAC_DEP_1: cx = ctrl_d1_reg;
			default:       cx = ctrl_d2_reg;
		endcase
	end

	chk_ctrl_depth: assert property (
		cdep == `DSPMAC_DEP_1 |-> cx.sign_a == $past(ctrl_i.sign_a))
		else $error("Control depth one mismatch");

	// ********************************************************************
	// Input stage, shift chains and multipliers
	// ********************************************************************
	dspmac_pkg::dspmac_lane_t a_reg [4];
	dspmac_pkg::dspmac_lane_t b_reg [4];
	dspmac_pkg::dspmac_lane_t a_ch [5];
	dspmac_pkg::dspmac_lane_t b_ch [5];
	dspmac_pkg::dspmac_lane_t a_use [4];
	dspmac_pkg::dspmac_lane_t b_use [4];
	dspmac_pkg::dspmac_prod_t prod_reg [4];
	dspmac_pkg::dspmac_prod_t prod_use [4];
	logic                     psg_reg [4];
	logic                     psg_use [4];

	assign a_ch[0] = shift_in_a_i;
	assign b_ch[0] = shift_in_b_i;
	assign shift_out_a_o = a_reg[3];
	assign shift_out_b_o = b_reg[3];

	for (genvar i = 0; i < 4; i++) begin : g_sub
		dspmac_pkg::dspmac_lane_t x;
		dspmac_pkg::dspmac_lane_t y;
		dspmac_pkg::dspmac_prod_t prod;
		logic                     xs;
		logic                     ys;

		assign a_ch[i+1] = a_reg[i];
		assign b_ch[i+1] = b_reg[i];

		// Operand registers: data chain, coefficient chain or parallel load
		always_ff @(posedge clock_i) begin
			if (!resetn_i || ctrl_i.clear[`DSPMAC_GRP_IN]) begin
				a_reg[i] <= '0;
				b_reg[i] <= '0;
			end else if (grp_en[`DSPMAC_GRP_IN]) begin
				a_reg[i] <= sh_a ? a_ch[i] : operand_a_lane_i[i];
				b_reg[i] <= sh_b ? b_ch[i] : operand_b_lane_i[i];
			end
		end

		// Row lanes A1,B1..A4,B4 bypass or use the register
		assign a_use[i] = (in_reg || sh_a) ? a_reg[i] : operand_a_lane_i[i];
		assign b_use[i] = (in_reg || sh_b) ? b_reg[i] : operand_b_lane_i[i];

		// Wide mode feeds halves of the 36-bit operands to each sub-block
		assign x = w36 ? a_use[i%2] : a_use[i];
		assign y = w36 ? b_use[i/2] : b_use[i];
		assign xs = cx.sign_a && (!w36 || (i%2 == 1));
		assign ys = cx.sign_b && (!w36 || (i/2 == 1));
		assign prod = mul18(x, y, xs, ys, h9);

		// Product register, also the wide multiplier's pipeline stage
		always_ff @(posedge clock_i) begin
			if (!resetn_i || ctrl_i.clear[`DSPMAC_GRP_PIPE]) begin
				prod_reg[i] <= '0;
				psg_reg[i] <= 1'b0;
			end else if (grp_en[`DSPMAC_GRP_PIPE]) begin
				prod_reg[i] <= prod;
				psg_reg[i] <= xs || ys;
			end
		end
		assign prod_use[i] = pipe_on ? prod_reg[i] : prod;
		assign psg_use[i] = pipe_on ? psg_reg[i] : (xs || ys);
	end

	chk_chain_shift: assert property (
		sh_a && in_step |=> a_reg[1] == $past(a_reg[0]))
		else $error("Data chain did not shift");

	chk_wide_noshift: assert property (
		w36 && in_step |=> a_reg[1] == $past(operand_a_lane_i[1]))
		else $error("Shift chain active in wide mode");

	// ********************************************************************
	// Adder stages and wide product
	// ********************************************************************
	dspmac_pkg::dspmac_wide_t e [4];
	dspmac_pkg::dspmac_wide_t pair [2];
	dspmac_pkg::dspmac_wide_t quad;
	dspmac_pkg::dspmac_wide_t wide;

	for (genvar i = 0; i < 4; i++) begin : g_ext
		assign e[i] = ext(prod_use[i], psg_use[i], h9);
	end

	// Pairs: real part by subtract, imaginary part by add
	assign pair[0] = as72(e[0], e[1], cx.add_subtract_select_upper, h9);
	assign pair[1] = as72(e[2], e[3], cx.add_subtract_select_lower, h9);
	assign quad = as72(pair[0], pair[1], 1'b1, h9);

	// Shifted partial products summed by the dedicated adder
	assign wide = ext(prod_use[0], psg_use[0], 1'b0)
		+ (ext(prod_use[1], psg_use[1], 1'b0) << `DSPMAC_LANE_W)
		+ (ext(prod_use[2], psg_use[2], 1'b0) << `DSPMAC_LANE_W)
		+ (ext(prod_use[3], psg_use[3], 1'b0) << `DSPMAC_PROD_W);

	// ********************************************************************
	// Accumulators
	// ********************************************************************
	dspmac_pkg::dspmac_acc_t acc_reg [2];
	logic                    ovf_reg [2];
	dspmac_pkg::dspmac_acc_t load_val0;

	for (genvar k = 0; k < 2; k++) begin : g_acc
		localparam int S = 2*k + 1;
		logic [`DSPMAC_ACC_W:0] ae;
		logic [`DSPMAC_ACC_W:0] pe;
		logic [`DSPMAC_ACC_W:0] tot;
		logic                   sub;
		logic                   ovf;

		// Only the second and fourth sub-blocks feed the totals
		always_comb begin
			ae = {psg_use[S] & acc_reg[k][`DSPMAC_ACC_W-1], acc_reg[k]};
			pe = {{(`DSPMAC_ACC_W-`DSPMAC_PROD_W+1){psg_use[S] & prod_use[S][35]}}, prod_use[S]};
			sub = (k == 0) ? !cx.add_subtract_select_upper : !cx.add_subtract_select_lower;
			if (cx.accum_load[k])
				tot = pe;
			else if (sub)
				tot = ae - pe;
			else
				tot = ae + pe;
			// Carry or borrow when unsigned, sign change when signed
			ovf = !cx.accum_load[k] && (psg_use[S] ? (tot[`DSPMAC_ACC_W] ^ tot[`DSPMAC_ACC_W-1])
				: tot[`DSPMAC_ACC_W]);
		end

		// Total wraps; flag is fresh each step
		always_ff @(posedge clock_i) begin
			if (!resetn_i || ctrl_i.clear[`DSPMAC_GRP_ACC]) begin
				acc_reg[k] <= '0;
				ovf_reg[k] <= 1'b0;
			end else if (grp_en[`DSPMAC_GRP_ACC]) begin
				if (is_mac)
					acc_reg[k] <= tot[`DSPMAC_ACC_W-1:0];
				ovf_reg[k] <= is_mac && ovf;
			end
		end
	end

	assign overflow_o = {ovf_reg[1], ovf_reg[0]};
	assign load_val0 = {{(`DSPMAC_ACC_W-`DSPMAC_PROD_W){psg_use[1] & prod_use[1][35]}}, prod_use[1]};

	chk_ovf_macmode: assert property (
		overflow_o != 2'h0 |-> $past(is_mac))
		else $error("Overflow outside accumulate mode");

	chk_acc_load: assert property (
		is_mac && acc_step && cx.accum_load[0] |=> acc_reg[0] == $past(load_val0))
		else $error("Load did not replace total");

	chk_ovf_notsticky: assert property (
		overflow_o[0] && is_mac && acc_step && cx.accum_load[0] |=> !overflow_o[0])
		else $error("Overflow flag held after load");

	// ********************************************************************
	// Output select and registers
	// ********************************************************************
	dspmac_pkg::dspmac_res_t res_next;
	dspmac_pkg::dspmac_res_t res_reg;

	// Select by mode
	always_comb begin
		case (mode)
			dspmac_pkg::DSPMAC_SIMPLE:
				if (w36)
					res_next = {{72{(cx.sign_a || cx.sign_b) & wide[71]}}, wide};
				else
					res_next = {prod_use[3], prod_use[2], prod_use[1], prod_use[0]};
			dspmac_pkg::DSPMAC_MAC:
				res_next = {{20{psg_use[3] & acc_reg[1][51]}}, acc_reg[1],
					{20{psg_use[1] & acc_reg[0][51]}}, acc_reg[0]};
			dspmac_pkg::DSPMAC_ADD2:
				res_next = {pair[1], pair[0]};
			default:
				res_next = {{72{quad[71]}}, quad};
		endcase
	end

	// Output register
	always_ff @(posedge clock_i) begin
		if (!resetn_i || ctrl_i.clear[`DSPMAC_GRP_OUT])
			res_reg <= '0;
		else if (grp_en[`DSPMAC_GRP_OUT])
			res_reg <= res_next;
	end

	// Eight rows: full lane to routing, nine bits each side
	assign result_lane_o = res_reg;
	for (genvar r = 0; r < 8; r++) begin : g_row
		assign result_left_o[r] = res_reg[r][8:0];
		assign result_right_o[r] = res_reg[r][17:9];
	end

	chk_mac_lane: assert property (
		is_mac && out_step |=> result_lane_o[2] == $past({{2{psg_use[1] & acc_reg[0][51]}}, acc_reg[0][51:36]}))
		else $error("Accumulator not on result lanes");

	// ********************************************************************
	// Bus slave
	// ********************************************************************
	logic                      aw_got;
	logic                      w_got;
	logic                      wr_go;
	logic [`DSPMAC_ADDR_W-1:0] aw_addr_reg;
	logic [31:0]               wdata_reg;
	logic [31:0]               wmask;
	logic [31:0]               stat_word;
	logic [3:0]                wstrb_reg;
	logic                      bvalid_reg;
	logic                      rvalid_reg;
	logic [1:0]                bresp_reg;
	logic [1:0]                rresp_reg;
	logic [31:0]               rdata_reg;

	assign axi_rsp_o.awready = !aw_got && !bvalid_reg;
	assign axi_rsp_o.wready = !w_got && !bvalid_reg;
	assign axi_rsp_o.bvalid = bvalid_reg;
	assign axi_rsp_o.bresp = bresp_reg;
	assign axi_rsp_o.arready = !rvalid_reg;
	assign axi_rsp_o.rvalid = rvalid_reg;
	assign axi_rsp_o.rdata = rdata_reg;
	assign axi_rsp_o.rresp = rresp_reg;
	assign wr_go = aw_got && w_got && !bvalid_reg;
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	// Status word shows live block state
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`DSPMAC_ST_OVF +: 2] = overflow_o;
		stat_word[`DSPMAC_ST_SHA] = sh_a;
		stat_word[`DSPMAC_ST_SHB] = sh_b;
		stat_word[`DSPMAC_ST_MODE +: 2] = mode;
		stat_word[`DSPMAC_ST_WIDTH +: 2] = cfg_reg[`DSPMAC_F_WIDTH +: 2];
	end

	// Address and data taken in either order
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (axi_req_i.awvalid && axi_rsp_o.awready) begin
				aw_got <= 1'b1;
				aw_addr_reg <= axi_req_i.awaddr;
			end else if (wr_go)
				aw_got <= 1'b0;
			if (axi_req_i.wvalid && axi_rsp_o.wready) begin
				w_got <= 1'b1;
				wdata_reg <= axi_req_i.wdata;
				wstrb_reg <= axi_req_i.wstrb;
			end else if (wr_go)
				w_got <= 1'b0;
		end
	end

	// Configuration write and write response
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			cfg_reg <= `DSPMAC_CFG_RST;
			bvalid_reg <= 1'b0;
			bresp_reg <= `DSPMAC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			if (aw_addr_reg == `DSPMAC_CFG_OFS) begin
				cfg_reg <= (cfg_reg & ~wmask) | (wdata_reg & wmask);
				bresp_reg <= `DSPMAC_RESP_OKAY;
			end else if (aw_addr_reg == `DSPMAC_STAT_OFS)
				bresp_reg <= `DSPMAC_RESP_OKAY;
			else
				bresp_reg <= `DSPMAC_RESP_SLVERR;
		end else if (axi_req_i.bready)
			bvalid_reg <= 1'b0;
	end

	// Read response
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `DSPMAC_RESP_OKAY;
		end else if (axi_req_i.arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			if (axi_req_i.araddr == `DSPMAC_CFG_OFS) begin
				rdata_reg <= cfg_reg;
				rresp_reg <= `DSPMAC_RESP_OKAY;
			end else if (axi_req_i.araddr == `DSPMAC_STAT_OFS) begin
				rdata_reg <= stat_word;
				rresp_reg <= `DSPMAC_RESP_OKAY;
			end else begin
				rdata_reg <= 32'h0000_0000;
				rresp_reg <= `DSPMAC_RESP_SLVERR;
			end
		end else if (axi_req_i.rready)
			rvalid_reg <= 1'b0;
	end

	chk_axi_bhold: assert property (
		bvalid_reg && !axi_req_i.bready |=> bvalid_reg && $stable(bresp_reg))
		else $error("Write response dropped early");

	chk_axi_unmapped: assert property (
		wr_go && aw_addr_reg != `DSPMAC_CFG_OFS && aw_addr_reg != `DSPMAC_STAT_OFS
		|=> bvalid_reg && bresp_reg == `DSPMAC_RESP_SLVERR)
		else $error("Unmapped write not refused");

endmodule : dspmac_block

// *** tb/dspmac_rows.sv ***
// Row model: the logic rows on both sides that pick up result halves.
// Assumes the block drives nine bits left and nine right per row.
`timescale 1ns/10ps
module dspmac_rows (
	input  wire logic [7:0][8:0]        left_i,
	input  wire logic [7:0][8:0]        right_i,
	output dspmac_pkg::dspmac_res_t     joined_o
);
	// Rows rejoin halves only; no adder on wide products here
	always_comb begin
		for (int r = 0; r < 8; r++) begin
			joined_o[r] = {right_i[r], left_i[r]};
		end
	end
endmodule : dspmac_rows

// *** tb/tb.sv ***
// Bench: register bus, simple multiply, accumulate, two-product adder.
// Assumes package, block and row model are compiled before it.
`timescale 1ns/10ps
`include "dspmac_regs.svh"
module tb;
	logic                           c = 0;
	logic                           rn = 0;
	dspmac_pkg::dspmac_axi_req_t    rq = '0;
	dspmac_pkg::dspmac_axi_rsp_t    rs;
	dspmac_pkg::dspmac_ctrl_t       ct = '{clock_en: 4'hf, ena: 4'hf, default: '0};
	dspmac_pkg::dspmac_lane_t [3:0] a = '0;
	dspmac_pkg::dspmac_lane_t [3:0] b = '0;
	dspmac_pkg::dspmac_lane_t       si = '0, so;
	dspmac_pkg::dspmac_res_t        lo, jo;
	logic [7:0][8:0]                lf, rt;
	logic [1:0]                     ov, r;
	logic [31:0]                    d;
	int                             n_mismatch = 0, check_count = 0, cyc = 0;
	always #50 c = ~c;
	dspmac_block dut_u (.clock_i(c), .resetn_i(rn), .axi_req_i(rq), .axi_rsp_o(rs), .ctrl_i(ct),
		.operand_a_lane_i(a), .operand_b_lane_i(b), .shift_in_a_i(si), .shift_in_b_i(18'h0_0000),
		.shift_out_a_o(so), .shift_out_b_o(), .result_lane_o(lo), .result_left_o(lf),
		.result_right_o(rt), .overflow_o(ov));
	dspmac_rows row_u (.left_i(lf), .right_i(rt), .joined_o(jo));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task cmp(input logic [71:0] g, input logic [71:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	task close_out;
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	// Cuts a hung run short
	always @(posedge c) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			close_out();
		end
	end
	// Each channel released at the edge that takes it
	task wr(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] resp);
		logic at, wt, bt;
		@(posedge c);
		rq.awvalid <= 1;
		rq.wvalid <= 1;
		rq.awaddr <= ad;
		rq.wdata <= wd;
		rq.wstrb <= 4'hf;
		rq.bready <= 1;
		do begin
			@(negedge c);
			at = rq.awvalid && rs.awready;
			wt = rq.wvalid && rs.wready;
			bt = rs.bvalid;
			resp = rs.bresp;
			@(posedge c);
			if (at) rq.awvalid <= 0;
			if (wt) rq.wvalid <= 0;
		end while (!bt);
		rq.bready <= 0;
	endtask : wr
	task rd(input logic [7:0] ad, output logic [31:0] rdv, output logic [1:0] resp);
		logic art, gt;
		@(posedge c);
		rq.arvalid <= 1;
		rq.araddr <= ad;
		rq.rready <= 1;
		do begin
			@(negedge c);
			art = rq.arvalid && rs.arready;
			gt = rs.rvalid;
			rdv = rs.rdata;
			resp = rs.rresp;
			@(posedge c);
			if (art) rq.arvalid <= 0;
		end while (!gt);
		rq.rready <= 0;
	endtask : rd
	task t_bus;
		rd(`DSPMAC_CFG_OFS, d, r);
		cmp(d, `DSPMAC_CFG_RST);
		cmp(r, `DSPMAC_RESP_OKAY);
		rd(8'h10, d, r);
		cmp(r, `DSPMAC_RESP_SLVERR);
		cmp(d, 32'h0000_0000);
		wr(`DSPMAC_STAT_OFS, 32'h0000_00ff, r);
		cmp(r, `DSPMAC_RESP_OKAY);
		rd(`DSPMAC_CFG_OFS, d, r);
		cmp(d, `DSPMAC_CFG_RST);
	endtask : t_bus
	task t_mul;
		@(posedge c);
		ct.sign_a <= 1;
		ct.sign_b <= 1;
		a[0] <= 18'h3_fffd;
		b[0] <= 18'h0_0005;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0004, r);
		repeat (3) @(negedge c);
		cmp({lo[1], lo[0]}, 36'hf_ffff_fff1);
		cmp({jo[1], jo[0]}, 36'hf_ffff_fff1);
	endtask : t_mul
	task t_mac;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0005, r);
		@(posedge c);
		a[1] <= 18'h0_0002;
		b[1] <= 18'h0_0003;
		ct.accum_load[0] <= 1;
		ct.add_subtract_select_upper <= 1;
		@(posedge c);
		ct.accum_load[0] <= 0;
		@(posedge c);
		ct.clock_en[2] <= 0;
		repeat (3) @(negedge c);
		cmp({lo[3], lo[2], lo[1], lo[0]}, 72'h0c);
		cmp(ov, 2'h0);
		// Unsigned: load 6, subtract to 0, then borrow wraps the total
		@(posedge c);
		ct.clock_en[2] <= 1;
		ct.sign_a <= 0;
		ct.sign_b <= 0;
		ct.add_subtract_select_upper <= 0;
		ct.accum_load[0] <= 1;
		@(posedge c);
		ct.accum_load[0] <= 0;
		repeat (2) @(posedge c);
		ct.accum_load[0] <= 1;
		@(negedge c);
		cmp(ov, 2'h1);
		@(posedge c);
		ct.accum_load[0] <= 0;
		ct.clock_en[2] <= 0;
		@(negedge c);
		cmp(ov, 2'h0);
		cmp({lo[3], lo[2], lo[1], lo[0]}, 72'h00_000f_ffff_ffff_fffa);
		@(posedge c);
		ct.clock_en[2] <= 1;
	endtask : t_mac
	task t_add2;
		a[0] <= 18'h0_0003;
		b[0] <= 18'h0_0004;
		a[1] <= 18'h0_0002;
		b[1] <= 18'h0_0001;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0006, r);
		for (int s = 0; s < 2; s++) begin
			@(posedge c);
			ct.add_subtract_select_upper <= s[0];
			repeat (3) @(negedge c);
			cmp({lo[3], lo[2], lo[1], lo[0]}, s ? 72'h0e : 72'h0a);
		end
		// Four products, all 18-bit: 14 + (1 - 0)
		@(posedge c);
		a[2] <= 18'h0_0001;
		b[2] <= 18'h0_0001;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0007, r);
		repeat (3) @(negedge c);
		cmp({lo[3], lo[2], lo[1], lo[0]}, 72'h0f);
	endtask : t_add2
	// Wide unsigned multiply, pipelined, shift request refused
	task t_wide;
		@(posedge c);
		a[0] <= 18'h0_0003;
		a[1] <= 18'h0_0001;
		b[0] <= 18'h0_0005;
		b[1] <= 18'h0_0002;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0178, r);
		repeat (4) @(negedge c);
		cmp({lo[3], lo[2], lo[1], lo[0]}, 72'h00_0000_0020_002c_000f);
		rd(`DSPMAC_STAT_OFS, d, r);
		cmp(d[`DSPMAC_ST_SHA], 1'b0);
	endtask : t_wide
	// One pulse through the four-stage data chain
	task t_chain;
		wr(`DSPMAC_CFG_OFS, 32'h0000_0044, r);
		rd(`DSPMAC_STAT_OFS, d, r);
		cmp(d[`DSPMAC_ST_SHA], 1'b1);
		@(posedge c);
		si <= 18'h0_0007;
		@(posedge c);
		si <= 18'h0_0000;
		repeat (3) @(posedge c);
		@(negedge c);
		cmp(so, 18'h0_0007);
	endtask : t_chain
	// Reset, then scenarios in turn
	initial begin
		repeat (8) @(posedge c);
		rn <= 1;
		t_bus();
		t_mul();
		t_mac();
		t_add2();
		t_wide();
		t_chain();
		close_out();
	end
endmodule : tb
